// ==== logic/ppao_top.sv ====
`timescale 1ns/1ps
// Functional notes
// R1 - Pull-up follows override, else pattern 010
// R2 - Pull-up override value forces pull-up state
// R3 - Driver enable follows direction override or bit
// R4 - Direction override value forces driver state
// R5 - Driven level from override or output latch
// R6 - Port value override ignores output latch
// R7 - Input enable follows override or sleep state
// R8 - Input override value forces input enable
// R9 - Digital input taken before port synchroniser
// R10 - Analog path attaches directly to pad
// R11 - Global pull-up disable kills all pull-ups
// R12 - Control register fields, reserved bits zero
// R13 - Pin change fires even on outputs
// R14 - Comparator pins: interrupt needs enables, unmasked
// R15 - Negative comparator pin input stays on asleep
// R16 - Positive comparator pin input stays on asleep
// R17 - Software: no output toggles during conversion
// R18 - Software: analog pins as inputs, no pull-up
// R19 - Only three pins overridden; reference pin more
// R20 - Overrides per pin; strobes shared per port
// R21 - Comparator pins: enable is group and disable
// R22 - Reference select disables reference pin drivers
// R23 - Direction bit one means output
// R24 - Override muxes purely combinational
module ppao_top
  import ppao_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic [7:0]          pad_in,
  input  wire logic                sleep_clamp,
  input  wire logic                comparator_disable,
  input  wire logic                reference_select_low,
  input  wire logic                pin_change_group_b_enable,
  input  wire logic                global_irq_enable,
  output ppao_pkg::ppao_pad_t [7:0] pad_ctrl,
  output logic      [7:0]          alt_digital_input,
  output logic                     pin_change_group_b,
  output logic                     global_pullup_disable,
  output logic                     sleep_enable_bit,
  output logic                     sleep_mode_select_hi,
  output logic                     sleep_mode_select_lo,
  output logic                     ext_irq_sense_hi,
  output logic                     ext_irq_sense_lo
);
  `include "ppao_cfg.svh"

  // ==========================================================
  // Declarations
  logic [7:0]      dir_q;
  logic [7:0]      latch_q;
  logic [7:0]      mcu_q;
  logic [7:0]      pin_sync;
  logic [7:0]      pin_prev_q;
  logic [1:0]      warm_q;
  logic [7:0]      rd_mux;
  logic [7:0]      pc_mask;
  logic [7:0]      pc_event;
  logic [7:0]      clamped_in;
  ppao_ovr_t [7:0] ovr;
  logic            port_latch_write_strobe;
  logic            direction_write_strobe;
  logic            mcu_write_strobe;
  logic            port_latch_read_strobe;
  logic            pin_read_strobe_port;
  logic            direction_read_strobe;
  logic            mcu_read_strobe;
  logic            pc_gate_cmp;
  logic            pc_gate_ref;

  // ==========================================================
  // Address match, shared by write and read decoding
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
    addr_hit = (addr == offs);
  endfunction

  // ==========================================================
  // Override values for each port pin, built by the owners' terms
  function automatic ppao_ovr_t ovr_for(input int idx,
                                        input logic cmp_off,
                                        input logic refs,
                                        input logic pcie);
    ppao_ovr_t o;
    o = '0;
    if (idx == `PPAO_PIN_CMP_NEG || idx == `PPAO_PIN_CMP_POS) begin
      o.input_enable_override_enable = pcie & cmp_off; // R21 R15 R16
      o.input_enable_override_value  = 1'b1; // R21
    end else if (idx == `PPAO_PIN_REF) begin
      o.pullup_override_enable       = refs; // R22
      o.pullup_override_value        = 1'b0; // R22
      o.direction_override_enable    = refs; // R22
      o.direction_override_value     = 1'b0; // R22
      o.input_enable_override_enable = pcie & ~refs; // R19
      o.input_enable_override_value  = 1'b1;
    end
    ovr_for = o;
  endfunction

  // ==========================================================
  // Port-wide access strobes, one set for all eight pins
  assign port_latch_write_strobe = reg_wr & addr_hit(reg_addr, `PPAO_ADDR_LATCH); // R20
  assign direction_write_strobe  = reg_wr & addr_hit(reg_addr, `PPAO_ADDR_DIR); // R20
  assign mcu_write_strobe        = reg_wr & addr_hit(reg_addr, `PPAO_ADDR_MCU);
  assign port_latch_read_strobe  = reg_rd & addr_hit(reg_addr, `PPAO_ADDR_LATCH);
  assign pin_read_strobe_port    = reg_rd & addr_hit(reg_addr, `PPAO_ADDR_PIN);
  assign direction_read_strobe   = reg_rd & addr_hit(reg_addr, `PPAO_ADDR_DIR);
  assign mcu_read_strobe         = reg_rd & addr_hit(reg_addr, `PPAO_ADDR_MCU);

  // ==========================================================
  // Read data select; unmapped addresses read as zero
  always_comb begin
    if (pin_read_strobe_port) begin
      rd_mux = pin_sync;
    end else if (direction_read_strobe) begin
      rd_mux = dir_q;
    end else if (port_latch_read_strobe) begin
      rd_mux = latch_q;
    end else if (mcu_read_strobe) begin
      rd_mux = mcu_q; // R12
    end else begin
      rd_mux = `PPAO_READ_IDLE;
    end
  end

  // ==========================================================
  // Port direction and output latch registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_q   <= `PPAO_PORT_RESET;
      latch_q <= `PPAO_PORT_RESET;
    end else begin
      if (direction_write_strobe) begin
        dir_q <= reg_wdata; // R23
      end
      if (port_latch_write_strobe) begin
        latch_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Control register; reserved bits masked so they stay zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mcu_q <= `PPAO_MCU_RESET; // R12
    end else if (mcu_write_strobe) begin
      mcu_q <= reg_wdata & `PPAO_MCU_WMASK; // R12
    end
  end

  // Read data stands one cycle only, zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `PPAO_READ_IDLE;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // Control fields presented to the sleep and interrupt logic
  assign global_pullup_disable = mcu_q[`PPAO_MCU_PULLOFF];
  assign sleep_enable_bit      = mcu_q[`PPAO_MCU_SLEEP_EN];
  assign sleep_mode_select_hi  = mcu_q[`PPAO_MCU_MODE_HI];
  assign sleep_mode_select_lo  = mcu_q[`PPAO_MCU_MODE_LO];
  assign ext_irq_sense_hi      = mcu_q[`PPAO_MCU_ISC1];
  assign ext_irq_sense_lo      = mcu_q[`PPAO_MCU_ISC0];

  // ==========================================================
  // Per-pin override logic; pad controls are not registered,
  // so an override change reaches the pad in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign ovr[gi] = ovr_for(gi, comparator_disable, reference_select_low,
                               pin_change_group_b_enable); // R19 R20
      ppao_pin_ctrl u_pin (
        .ovr                   (ovr[gi]),
        .pin_direction_bit     (dir_q[gi]),
        .pin_output_latch_bit  (latch_q[gi]),
        .global_pullup_disable (mcu_q[`PPAO_MCU_PULLOFF]), // R11
        .sleep_clamp           (sleep_clamp),
        .pad_in                (pad_in[gi]),
        .pad                   (pad_ctrl[gi]), // R24
        .alt_digital_input     (alt_digital_input[gi]) // R9
      );
      assign clamped_in[gi] = alt_digital_input[gi];
    end
  endgenerate

  // Analog path never enters this logic: pad ring ties it to pad R10

  // ==========================================================
  // Port synchroniser for the pin read register and pin change
  ppao_sync u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (clamped_in),
    .sync_out (pin_sync)
  );

  // ==========================================================
  // Pin change gating; direction is deliberately not looked at,
  // so software toggling an output still raises the event
  assign pc_gate_cmp = global_irq_enable & pin_change_group_b_enable & comparator_disable; // R14
  assign pc_gate_ref = global_irq_enable & pin_change_group_b_enable & ~reference_select_low;

  always_comb begin
    pc_mask                   = 8'h00;
    pc_mask[`PPAO_PIN_CMP_NEG] = pc_gate_cmp; // R13 R14
    pc_mask[`PPAO_PIN_CMP_POS] = pc_gate_cmp; // R13 R14
    pc_mask[`PPAO_PIN_REF]     = pc_gate_ref; // R13
  end

  // No event until the history holds a real pad sample, so a pin
  // that idles high does not look like a change just after reset
  assign pc_event = (pin_sync ^ pin_prev_q) & pc_mask & {8{warm_q == `PPAO_WARM_DONE}}; // R13

  // Warm-up count: synchroniser plus history need three edges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      warm_q <= 2'h0;
    end else if (warm_q != `PPAO_WARM_DONE) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  // Edge history and one-cycle event pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_prev_q         <= 8'h00;
      pin_change_group_b <= 1'b0;
    end else begin
      pin_prev_q         <= pin_sync;
      pin_change_group_b <= |pc_event; // R13
    end
  end
endmodule

// ==== logic/ppao_cfg.svh ====
`ifndef PPAO_CFG_SVH
`define PPAO_CFG_SVH

// ==========================================================
// Register offsets on the plain register port
`define PPAO_ADDR_PIN        8'h10
`define PPAO_ADDR_DIR        8'h11
`define PPAO_ADDR_LATCH      8'h12
`define PPAO_ADDR_MCU        8'h35

// ==========================================================
// Reset values and write masks
`define PPAO_PORT_RESET      8'h00
`define PPAO_MCU_RESET       8'h00
`define PPAO_MCU_WMASK       8'h7b
`define PPAO_READ_IDLE       8'h00

// ==========================================================
// Control register field positions
`define PPAO_MCU_PULLOFF     6
`define PPAO_MCU_SLEEP_EN    5
`define PPAO_MCU_MODE_HI     4
`define PPAO_MCU_MODE_LO     3
`define PPAO_MCU_ISC1        1
`define PPAO_MCU_ISC0        0

// ==========================================================
// Port A pins that carry alternate-function overrides
`define PPAO_PIN_CMP_NEG     7
`define PPAO_PIN_CMP_POS     6
`define PPAO_PIN_REF         3

// ==========================================================
// Default pull-up term {direction, latch, pull-up disable}
`define PPAO_PULLUP_PATTERN  3'h2

// ==========================================================
// Edges after reset before the pin history holds real samples
`define PPAO_WARM_DONE       2'h3

`endif

// ==== logic/ppao_pkg.sv ====
package ppao_pkg;

  // ==========================================================
  // Override bundle produced by the alternate-function owner
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic port_value_override_enable;
    logic port_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } ppao_ovr_t;

  // ==========================================================
  // Resolved pad controls for one pin
  typedef struct packed {
    logic pullup_en;
    logic drive_en;
    logic drive_val;
    logic input_en;
  } ppao_pad_t;

endpackage

// ==== logic/ppao_sync.sv ====
`timescale 1ns/1ps
module ppao_sync (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  logic [7:0] meta_q;

  // ==========================================================
  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q   <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== logic/ppao_pin_ctrl.sv ====
`timescale 1ns/1ps
module ppao_pin_ctrl
  import ppao_pkg::*;
(
  input  ppao_pkg::ppao_ovr_t ovr,
  input  wire logic           pin_direction_bit,
  input  wire logic           pin_output_latch_bit,
  input  wire logic           global_pullup_disable,
  input  wire logic           sleep_clamp,
  input  wire logic           pad_in,
  output ppao_pkg::ppao_pad_t pad,
  output logic                alt_digital_input
);
  `include "ppao_cfg.svh"

  logic dflt_pullup;
  logic port_value;
  logic dflt_input_en;

  // ==========================================================
  // Default terms; no register so overrides act at once
  assign dflt_pullup   = ({pin_direction_bit, pin_output_latch_bit, global_pullup_disable}
                          == `PPAO_PULLUP_PATTERN); // R1 R11 R24
  assign dflt_input_en = ~sleep_clamp;

  // Override multiplexers
  assign pad.pullup_en = ovr.pullup_override_enable ? ovr.pullup_override_value : dflt_pullup; // R1 R2
  assign pad.drive_en  = ovr.direction_override_enable ? ovr.direction_override_value
                                                        : pin_direction_bit; // R3 R4 R23
  assign port_value    = ovr.port_value_override_enable ? ovr.port_value_override_value
                                                        : pin_output_latch_bit; // R6
  assign pad.drive_val = pad.drive_en & port_value; // R5
  assign pad.input_en  = ovr.input_enable_override_enable ? ovr.input_enable_override_value
                                                           : dflt_input_en; // R7 R8

  // Raw gated input, ahead of any synchroniser
  assign alt_digital_input = pad_in & pad.input_en; // R9
endmodule

// ==== bench/ppao_monitor.sv ====
`timescale 1ns/1ps
`include "ppao_cfg.svh"
// ==========================================================
// Port-level checks beside the pin override block
module ppao_monitor
  import ppao_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic [7:0]           reg_addr,
  input wire logic [7:0]           reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  input wire logic [7:0]           pad_in,
  input wire logic                 sleep_clamp,
  input wire logic                 comparator_disable,
  input wire logic                 reference_select_low,
  input wire logic                 pin_change_group_b_enable,
  input wire logic                 global_irq_enable,
  input ppao_pkg::ppao_pad_t [7:0] pad_ctrl,
  input wire logic [7:0]           alt_digital_input,
  input wire logic                 pin_change_group_b,
  input wire logic                 global_pullup_disable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] ien, pup, den, dval;

  // Flatten the per-pin structs so checks read as vectors
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ien[i]  = pad_ctrl[i].input_en;
      pup[i]  = pad_ctrl[i].pullup_en;
      den[i]  = pad_ctrl[i].drive_en;
      dval[i] = pad_ctrl[i].drive_val;
    end
  end

  // ==========================================================
  // Pad control relations
  AST_ALT_RAW: assert property (alt_digital_input == (pad_in & ien))
    else $error("alt input differs from pad and enable");
  AST_NOPULL_ALL: assert property (global_pullup_disable |-> pup == 8'h00)
    else $error("pull-up on while globally disabled");
  AST_REF_PIN: assert property (reference_select_low |-> !pup[3] && !den[3])
    else $error("reference pin still driven or pulled");
  AST_CMP_IEN: assert property (pin_change_group_b_enable && comparator_disable |-> ien[7] && ien[6])
    else $error("comparator pin input not kept on");
  AST_PLAIN_IEN: assert property ({ien[5:4], ien[2:0]} == {5{!sleep_clamp}})
    else $error("plain pin input enable wrong");
  AST_CLAMP: assert property (sleep_clamp && !comparator_disable |-> !ien[7] && !ien[6])
    else $error("comparator pin input not clamped");
  AST_DVAL: assert property ((dval & ~den) == 8'h00)
    else $error("level driven with driver off");
  AST_PULL_DRV: assert property ((pup & den) == 8'h00)
    else $error("pull-up on a driven pin");
  // ==========================================================
  // Register port and event relations
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_MCU_WR: assert property (reg_wr && reg_addr == `PPAO_ADDR_MCU |=> global_pullup_disable == $past(reg_wdata[6]))
    else $error("pull-up disable not written");
  AST_MCU_RD: assert property (reg_rd && reg_addr == `PPAO_ADDR_MCU |=>
    reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0 && reg_rdata[6] == global_pullup_disable)
    else $error("control read wrong");
  AST_PCHG_GATE: assert property (!global_irq_enable [*3] |-> !pin_change_group_b)
    else $error("pin change with interrupts off");
  COV_PCHG: cover property (pin_change_group_b);
  COV_REF: cover property (reference_select_low && den != 8'h00);
  COV_SLEEP: cover property (sleep_clamp && pin_change_group_b_enable && comparator_disable);
endmodule

bind ppao_top ppao_monitor i_ppao_monitor (.*);

// ==== bench/ppao_pad_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Pad and far-side model: resolves each pin from its controls
module ppao_pad_model
  import ppao_pkg::*;
(
  input wire logic                 mclk,
  input ppao_pkg::ppao_pad_t [7:0] pad_ctrl,
  input wire logic [7:0]           ext_level,
  input wire logic [7:0]           ext_drive,
  output logic [7:0]               pad_in
);
  logic [7:0] last_q = 8'h00;

  // Floating pads flip every cycle so a stale level never looks valid
  always_ff @(posedge mclk) last_q <= pad_in;

  // Own driver wins, then outside driver, then pull-up; analog side sits on the pad itself
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_ctrl[i].drive_en) pad_in[i] = pad_ctrl[i].drive_val;
      else if (ext_drive[i]) pad_in[i] = ext_level[i];
      else if (pad_ctrl[i].pullup_en) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_q[i];
    end
  end
endmodule

// ==== bench/port_pin_alternate_override_tb.sv ====
`timescale 1ns/1ps
`include "ppao_cfg.svh"
// ==========================================================
// Self-checking bench for the pin override block
module port_pin_alternate_override_tb;
  import ppao_pkg::*;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sleep_clamp = 0, comparator_disable = 0;
  logic reference_select_low = 0, pin_change_group_b_enable = 0, global_irq_enable = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, ext_level = 0, ext_drive = 8'hff;
  logic [7:0] pad_in, reg_rdata, alt_digital_input, dir, lat, v, r, ienx, fl;
  logic pin_change_group_b, global_pullup_disable, sleep_enable_bit, sleep_mode_select_hi;
  logic sleep_mode_select_lo, ext_irq_sense_hi, ext_irq_sense_lo, mpud;
  ppao_pad_t [7:0] pad_ctrl;
  int miscompares = 0, comparisons = 0;

  always #5 mclk = ~mclk;

  ppao_top i_ppao_top (.*);
  ppao_pad_model i_ppao_pad_model (.*);

  // ==========================================================
  // Shared helpers
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus cycles leave one idle slot so no strobe is assigned twice per step
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask

  // Expected pad controls worked out from configuration and side inputs
  function automatic ppao_pad_t exp_pad(int i);
    logic off;
    off = (i == `PPAO_PIN_REF) && reference_select_low;
    exp_pad.drive_en = dir[i] & !off;
    exp_pad.drive_val = dir[i] & !off & lat[i];
    exp_pad.pullup_en = !off & !dir[i] & lat[i] & !mpud;
    exp_pad.input_en = !sleep_clamp | ((i == 7 || i == 6) ? pin_change_group_b_enable & comparator_disable :
      (i == `PPAO_PIN_REF) ? pin_change_group_b_enable & !reference_select_low : 1'b0);
  endfunction

  // Floating pads toggle in the model, so their level is masked later
  task pins;
    ppao_pad_t e;
    for (int i = 0; i < 8; i++) begin
      e = exp_pad(i);
      ienx[i] = e.input_en;
      fl[i] = !e.drive_en & !e.pullup_en & !ext_drive[i];
      chk("pad control", {4'h0, pad_ctrl[i]}, {4'h0, e});
    end
    chk("alt input", alt_digital_input, pad_in & ienx);
  endtask

  // Count event pulses over a fixed window
  task pulses(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      n += (pin_change_group_b === 1'b1);
    end
    @(posedge mclk);
    chk("pin change pulses", n[7:0], exp);
  endtask

  task tog(input int p, input logic [7:0] exp);
    wr(`PPAO_ADDR_LATCH, 8'h01 << p);
    pulses(exp);
    wr(`PPAO_ADDR_LATCH, 8'h00);
    pulses(exp);
  endtask

  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hf351ad8a));
    dir = 8'h00;
    lat = 8'h00;
    mpud = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`PPAO_ADDR_MCU, r);
    chk("control reset", r, `PPAO_MCU_RESET);
    rd(`PPAO_ADDR_DIR, r);
    chk("direction reset", r, `PPAO_PORT_RESET);
    pins;
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 8'hff : (k == 1) ? 8'h84 : 8'($urandom);
      wr(`PPAO_ADDR_MCU, v);
      rd(`PPAO_ADDR_MCU, r);
      chk("control read", r, v & `PPAO_MCU_WMASK);
      r = {1'b0, global_pullup_disable, sleep_enable_bit, sleep_mode_select_hi, sleep_mode_select_lo,
        1'b0, ext_irq_sense_hi, ext_irq_sense_lo};
      chk("control bits", r, v & `PPAO_MCU_WMASK);
    end
    wr(8'h77, 8'hff);
    rd(8'h77, r);
    chk("unmapped read", r, `PPAO_READ_IDLE);
    $display("test control register done");
    for (int k = 0; k < 24; k++) begin
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      lat = (k < 2) ? 8'hff : 8'($urandom);
      mpud = (k == 2) ? 1'b1 : 1'($urandom);
      ext_level <= 8'($urandom);
      ext_drive <= (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      sleep_clamp <= 1'($urandom);
      comparator_disable <= 1'($urandom);
      pin_change_group_b_enable <= 1'($urandom);
      reference_select_low <= (k == 3) ? 1'b1 : 1'($urandom);
      global_irq_enable <= 1'($urandom);
      wr(`PPAO_ADDR_DIR, dir);
      wr(`PPAO_ADDR_LATCH, lat);
      wr(`PPAO_ADDR_MCU, {1'b0, mpud, 6'h00});
      repeat (3) @(posedge mclk);
      #1 pins;
      @(posedge mclk);
      rd(`PPAO_ADDR_PIN, r);
      chk("pin register", r & ~fl, pad_in & ienx & ~fl);
    end
    $display("test pad configurations done");
    // Event pins driven as outputs still raise the event
    ext_level <= 8'h00;
    ext_drive <= 8'hff;
    sleep_clamp <= 1'b0;
    reference_select_low <= 1'b0;
    global_irq_enable <= 1'b1;
    pin_change_group_b_enable <= 1'b1;
    comparator_disable <= 1'b1;
    wr(`PPAO_ADDR_MCU, 8'h00);
    wr(`PPAO_ADDR_LATCH, 8'h00);
    // No conversion runs in this bench, so toggling port outputs is safe
    wr(`PPAO_ADDR_DIR, 8'hc8 | 8'h20);
    // Let the setup transient drain before the quiet window
    repeat (4) @(posedge mclk);
    pulses(8'h00);
    tog(7, 8'h01);
    tog(6, 8'h01);
    tog(3, 8'h01);
    tog(5, 8'h00);
    comparator_disable <= 1'b0;
    tog(7, 8'h00);
    tog(3, 8'h01);
    global_irq_enable <= 1'b0;
    tog(3, 8'h00);
    $display("test pin change done");
    results;
  end
endmodule
